// *** core/wdw_pkg.sv ***
// Purpose: Shared constants and types for the watchdog and wake-up block
// Assumes: Register port with one-cycle read latency, 100 MHz system clock
// Notes:   Register offsets are local choices
`default_nettype none
package wdw_pkg;
    localparam logic [3:0] ADDR_WDT_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_RST_CAUSE   = 4'h1;
    localparam logic [3:0] ADDR_STATUS      = 4'h2;
    localparam logic [3:0] ADDR_PA_WAKE     = 4'h3;
    localparam logic [3:0] ADDR_INT_CTRL    = 4'h4;
    localparam logic [7:0] WDT_CTRL_RESET   = 8'h53;
    localparam logic [4:0] KEY_A            = 5'h0a;
    localparam logic [4:0] KEY_B            = 5'h15;
    localparam int         KEY_LSB          = 3;
    localparam int         SOFT_FLAG_BIT    = 0;
    localparam int         UV_FLAG_BIT      = 2;
    localparam int         CNT_W            = 19;
    localparam int         SRESET_NS        = 100;
    localparam int         CLK_PERIOD_NS    = 10;
    localparam int         SRESET_CYC       = (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SRESET_CYC_W     = 4'(SRESET_CYC);
    localparam logic [7:0] PA_WAKE_RESET    = 8'h00;

    typedef enum logic [1:0] {
        WDW_RUN   = 2'b00,
        WDW_HALT  = 2'b01,
        WDW_SRST  = 2'b10
    } wdw_mode_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } wdw_bus_type;

    typedef struct packed {
        wdw_mode_type     mode;
        logic [7:0]       ctrl;
        logic             soft_flag;
        logic             uv_flag;
        logic             timeout_flag;
        logic             powerdown_flag;
        logic [7:0]       pa_wake_en;
        logic [7:0]       pa_prev;
        logic [CNT_W-1:0] count;
        logic             tick_prev;
        logic [3:0]       srst_cnt;
        logic             full_reset;
        logic             core_reset;
        logic             wake;
        logic             service_int;
        logic [7:0]       int_pending_at_halt;
        logic [7:0]       rdata;
    } wdw_state_type;
endpackage : wdw_pkg
`default_nettype wire

// *** core/wdw_watchdog.sv ***
// Purpose: Watchdog timer, guard key reset, halt and wake-up control
// Assumes: slow_osc_in is the slow oscillator sampled as a level on clk_in
// Notes:   One struct holds all state; one comb fills it, one ff stores it
//
// Operation
// RULE_01: Counter advances on each rising edge of the slow oscillator.
// RULE_02: Timeout select codes 000..110 pick 2^8..2^17 slow clocks.
// RULE_03: Ratios span 2^8 to 2^18, the latter the longest.
// RULE_04: Code 111 selects the 2^18 ratio.
// RULE_05: Guard key 01010 or 10101 keeps the watchdog enabled.
// RULE_06: Any other guard key resets the device after a fixed delay.
// RULE_07: An invalid-key reset sets the soft reset cause flag.
// RULE_08: Only a software write of zero clears the soft reset flag. The code also clears it on rst_in.
// RULE_09: Power-on loads guard key 01010, watchdog enabled.
// RULE_10: Overflow while running gives full reset and sets timeout flag.
// RULE_11: Overflow while halted sets timeout flag, resets PC/SP, wakes.
// RULE_12: Invalid key, clear instruction or halt clear the counter.
// RULE_13: Software clears the watchdog before timeout elapses.
// RULE_14: Halt enters idle or sleep and sets power-down flag.
// RULE_15: Power-up or clear instruction clears power-down flag.
// RULE_16: Port A falling edge, interrupt, or overflow end halt.
// RULE_17: Each Port A pin has a wake enable; wake resumes after halt.
// RULE_18: Disabled or stack-full interrupt wake resumes without service.
// RULE_19: Enabled interrupt with stack room is serviced at once.
// RULE_20: Request pending at halt entry does not wake the device.
// RULE_21: Watchdog keeps counting while halted.
// RULE_22: Overflow flags when count reaches the selected power of two.
//
// Our own choices: the register offsets and the plain strobed port.
`default_nettype none
module wdw_watchdog (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       slow_osc_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       clear_watchdog_instr_in,
    input  wire logic       halt_in,
    input  wire logic [7:0] porta_in,
    input  wire logic [7:0] int_req_in,
    input  wire logic [7:0] int_en_in,
    input  wire logic       stack_full_in,
    input  wire logic       undervoltage_in,
    output logic            halted_out,
    output logic            wake_out,
    output logic            service_int_out,
    output logic            core_reset_out,
    output logic            full_reset_out
);
    wdw_pkg::wdw_state_type st_reg;
    wdw_pkg::wdw_state_type st_next;
    wdw_pkg::wdw_bus_type   bus;

    assign bus = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

    function automatic logic key_ok(input logic [4:0] key);
        key_ok = (key == wdw_pkg::KEY_A) || (key == wdw_pkg::KEY_B); // RULE_05
    endfunction : key_ok

    // Bit index of the selected overflow count
    function automatic logic [4:0] sel_bit(input logic [2:0] sel);
        unique case (sel)
            3'h0: sel_bit = 5'h08; // RULE_02
            3'h1: sel_bit = 5'h0a;
            3'h2: sel_bit = 5'h0c;
            3'h3: sel_bit = 5'h0e;
            3'h4: sel_bit = 5'h0f;
            3'h5: sel_bit = 5'h10;
            3'h6: sel_bit = 5'h11;
            3'h7: sel_bit = 5'h12; // RULE_03 RULE_04
        endcase
    endfunction : sel_bit

    logic       tick;
    logic       overflow;
    logic [7:0] wake_ints;
    logic [7:0] pa_fall;
    logic [4:0] key_now;

    assign key_now  = st_reg.ctrl[7:wdw_pkg::KEY_LSB];
    assign tick     = slow_osc_in && !st_reg.tick_prev; // RULE_01
    assign overflow = st_reg.count[sel_bit(st_reg.ctrl[2:0])]; // RULE_22
    assign pa_fall  = st_reg.pa_prev & ~porta_in & st_reg.pa_wake_en; // RULE_17
    assign wake_ints = int_req_in & ~st_reg.int_pending_at_halt; // RULE_20

    always_comb begin
        st_next             = st_reg;
        st_next.tick_prev   = slow_osc_in;
        st_next.pa_prev     = porta_in;
        st_next.full_reset  = 1'b0;
        st_next.core_reset  = 1'b0;
        st_next.wake        = 1'b0;
        st_next.service_int = 1'b0;
        st_next.rdata       = 8'h00;
        st_next.uv_flag     = st_reg.uv_flag | undervoltage_in;

        // Counter runs in run and halt modes; the reset delay state holds it clear
        if (tick) begin
            st_next.count = st_reg.count + 1'b1; // RULE_21
        end

        if (bus.rd) begin
            unique case (bus.addr)
                wdw_pkg::ADDR_WDT_CTRL:  st_next.rdata = st_reg.ctrl;
                wdw_pkg::ADDR_RST_CAUSE: st_next.rdata = {5'h00, st_reg.uv_flag, 1'b0,
                                                          st_reg.soft_flag};
                wdw_pkg::ADDR_STATUS:    st_next.rdata = {6'h00, st_reg.timeout_flag,
                                                          st_reg.powerdown_flag};
                wdw_pkg::ADDR_PA_WAKE:   st_next.rdata = st_reg.pa_wake_en;
                default:                 st_next.rdata = 8'h00;
            endcase
        end
        if (bus.wr) begin
            unique case (bus.addr)
                wdw_pkg::ADDR_WDT_CTRL:  st_next.ctrl = bus.wdata;
                wdw_pkg::ADDR_RST_CAUSE: begin
                    if (!bus.wdata[wdw_pkg::SOFT_FLAG_BIT]) begin
                        st_next.soft_flag = 1'b0; // RULE_08
                    end
                    if (!bus.wdata[wdw_pkg::UV_FLAG_BIT]) begin
                        st_next.uv_flag = undervoltage_in;
                    end
                end
                wdw_pkg::ADDR_PA_WAKE:   st_next.pa_wake_en = bus.wdata;
                default: ;
            endcase
        end

        unique case (st_reg.mode)
            wdw_pkg::WDW_RUN: begin
                if (!key_ok(key_now)) begin
                    st_next.mode     = wdw_pkg::WDW_SRST; // RULE_06
                    st_next.srst_cnt = 4'h0;
                    st_next.count    = '0; // RULE_12
                end else if (halt_in) begin
                    st_next.mode                = wdw_pkg::WDW_HALT; // RULE_14
                    st_next.powerdown_flag      = 1'b1;
                    st_next.timeout_flag        = 1'b0;
                    st_next.count               = '0; // RULE_12
                    st_next.int_pending_at_halt = int_req_in;
                end else if (clear_watchdog_instr_in) begin
                    st_next.count          = '0; // RULE_12 RULE_13
                    st_next.powerdown_flag = 1'b0; // RULE_15
                    st_next.timeout_flag   = 1'b0;
                end else if (overflow) begin
                    // Full reset: control back to power-on value, cause flags kept
                    st_next.full_reset     = 1'b1; // RULE_10
                    st_next.timeout_flag   = 1'b1;
                    st_next.powerdown_flag = 1'b0;
                    st_next.count          = '0;
                    st_next.ctrl           = wdw_pkg::WDT_CTRL_RESET;
                    st_next.pa_wake_en     = wdw_pkg::PA_WAKE_RESET;
                end
            end
            wdw_pkg::WDW_HALT: begin
                if (!key_ok(key_now)) begin
                    st_next.mode     = wdw_pkg::WDW_SRST;
                    st_next.srst_cnt = 4'h0;
                    st_next.count    = '0;
                end else if (overflow) begin
                    st_next.mode         = wdw_pkg::WDW_RUN; // RULE_11 RULE_16
                    st_next.timeout_flag = 1'b1;
                    st_next.core_reset   = 1'b1;
                    st_next.wake         = 1'b1;
                    st_next.count        = '0;
                end else if ((|pa_fall) || (|wake_ints)) begin
                    st_next.mode        = wdw_pkg::WDW_RUN; // RULE_16 RULE_17
                    st_next.wake        = 1'b1; // RULE_18
                    st_next.service_int = |(wake_ints & int_en_in) && !stack_full_in; // RULE_19
                end
            end
            wdw_pkg::WDW_SRST: begin
                // Hold the counter clear while the reset delay runs out
                st_next.count    = '0;
                st_next.srst_cnt = st_reg.srst_cnt + 1'b1;
                if (st_reg.srst_cnt == wdw_pkg::SRESET_CYC_W - 4'h1) begin
                    st_next.mode           = wdw_pkg::WDW_RUN;
                    st_next.full_reset     = 1'b1; // RULE_06
                    st_next.soft_flag      = 1'b1; // RULE_07
                    st_next.ctrl           = wdw_pkg::WDT_CTRL_RESET;
                    st_next.pa_wake_en     = wdw_pkg::PA_WAKE_RESET;
                    st_next.timeout_flag   = 1'b0;
                    st_next.powerdown_flag = 1'b0;
                    st_next.srst_cnt       = 4'h0;
                end
            end
            default: st_next.mode = wdw_pkg::WDW_RUN;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg                     <= '0;
            st_reg.mode                <= wdw_pkg::WDW_RUN;
            st_reg.ctrl                <= wdw_pkg::WDT_CTRL_RESET; // RULE_09
            st_reg.pa_wake_en          <= wdw_pkg::PA_WAKE_RESET;
            st_reg.powerdown_flag      <= 1'b0; // RULE_15
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out   = st_reg.rdata;
    assign halted_out      = (st_reg.mode == wdw_pkg::WDW_HALT);
    assign wake_out        = st_reg.wake;
    assign service_int_out = st_reg.service_int;
    assign core_reset_out  = st_reg.core_reset;
    assign full_reset_out  = st_reg.full_reset;

    sequence s_key_bad;
        st_reg.mode != wdw_pkg::WDW_SRST && !key_ok(key_now);
    endsequence

    sequence s_soft_reset_done;
        full_reset_out && st_reg.soft_flag && st_reg.ctrl == wdw_pkg::WDT_CTRL_RESET;
    endsequence

    sequence s_halt_taken;
        st_reg.mode == wdw_pkg::WDW_RUN && key_ok(key_now) && halt_in;
    endsequence

    // One edge to enter the delay state, nine to run it out, one to register the pulse
    property p_bad_key_resets;
        @(posedge clk_in) disable iff (rst_in)
        s_key_bad |-> ##11 s_soft_reset_done;
    endproperty
    a_bad_key_resets: assert property (p_bad_key_resets) // RULE_06
        else $error("invalid key did not reset after delay");

    property p_soft_flag_sticky;
        @(posedge clk_in) disable iff (rst_in)
        (st_reg.soft_flag && !(bus.wr && bus.addr == wdw_pkg::ADDR_RST_CAUSE))
            |=> st_reg.soft_flag;
    endproperty
    a_soft_flag_sticky: assert property (p_soft_flag_sticky) // RULE_08
        else $error("soft reset flag cleared without a write");

    property p_halt_sets_pd;
        @(posedge clk_in) disable iff (rst_in)
        (st_reg.mode == wdw_pkg::WDW_RUN && key_ok(key_now) && halt_in)
            |=> (halted_out && st_reg.powerdown_flag && st_reg.count == '0);
    endproperty
    a_halt_sets_pd: assert property (p_halt_sets_pd) // RULE_14
        else $error("halt did not enter power-down");

    property p_clr_clears;
        @(posedge clk_in) disable iff (rst_in)
        (st_reg.mode == wdw_pkg::WDW_RUN && key_ok(key_now) && !halt_in && clear_watchdog_instr_in)
            |=> (!st_reg.powerdown_flag && st_reg.count == '0);
    endproperty
    a_clr_clears: assert property (p_clr_clears) // RULE_15
        else $error("clear instruction did not clear counter and flag");

    property p_run_overflow;
        @(posedge clk_in) disable iff (rst_in)
        (st_reg.mode == wdw_pkg::WDW_RUN && key_ok(key_now) && !halt_in && !clear_watchdog_instr_in
            && overflow) |=> (full_reset_out && st_reg.timeout_flag);
    endproperty
    a_run_overflow: assert property (p_run_overflow) // RULE_10
        else $error("overflow in run mode did not reset");

    property p_halt_overflow;
        @(posedge clk_in) disable iff (rst_in)
        (halted_out && key_ok(key_now) && overflow)
            |=> (wake_out && core_reset_out && !full_reset_out && st_reg.timeout_flag
                 && $stable(st_reg.ctrl));
    endproperty
    a_halt_overflow: assert property (p_halt_overflow) // RULE_11
        else $error("overflow while halted handled wrongly");

    property p_pin_wake;
        @(posedge clk_in) disable iff (rst_in)
        (halted_out && key_ok(key_now) && |pa_fall) |=> (wake_out && !halted_out);
    endproperty
    a_pin_wake: assert property (p_pin_wake) // RULE_17
        else $error("enabled pin edge did not wake");

    property p_no_pending_wake;
        @(posedge clk_in) disable iff (rst_in)
        (halted_out && key_ok(key_now) && !overflow && pa_fall == 8'h00 && wake_ints == 8'h00)
            |=> halted_out;
    endproperty
    a_no_pending_wake: assert property (p_no_pending_wake) // RULE_20
        else $error("woke without a valid source");

    property p_service;
        @(posedge clk_in) disable iff (rst_in)
        (halted_out && key_ok(key_now) && !overflow && pa_fall == 8'h00 && |wake_ints)
            |=> (service_int_out == ($past(|(wake_ints & int_en_in)) && $past(!stack_full_in)));
    endproperty
    a_service: assert property (p_service) // RULE_18
        else $error("interrupt wake service decision wrong");

    property p_srst_quiet;
        @(posedge clk_in) disable iff (rst_in)
        (st_reg.mode == wdw_pkg::WDW_SRST && st_reg.srst_cnt != wdw_pkg::SRESET_CYC_W - 4'h1)
            |=> (st_reg.mode == wdw_pkg::WDW_SRST && !full_reset_out && st_reg.count == '0);
    endproperty
    a_srst_quiet: assert property (p_srst_quiet) // RULE_06 RULE_12
        else $error("reset delay ended early or counter moved");

    property p_run_tick;
        @(posedge clk_in) disable iff (rst_in)
        (st_reg.mode == wdw_pkg::WDW_RUN && key_ok(key_now) && !halt_in && !clear_watchdog_instr_in
            && !overflow && tick) |=> (st_reg.count == $past(st_reg.count) + 1'b1);
    endproperty
    a_run_tick: assert property (p_run_tick) // RULE_01
        else $error("slow clock edge did not advance the counter");

    property p_halt_tick;
        @(posedge clk_in) disable iff (rst_in)
        (halted_out && key_ok(key_now) && !overflow && tick)
            |=> (st_reg.count == $past(st_reg.count) + 1'b1);
    endproperty
    a_halt_tick: assert property (p_halt_tick) // RULE_21
        else $error("counter stopped while halted");

    property p_count_hold;
        @(posedge clk_in) disable iff (rst_in)
        (st_reg.mode != wdw_pkg::WDW_SRST && key_ok(key_now) && !tick && !halt_in
            && !clear_watchdog_instr_in && !overflow) |=> $stable(st_reg.count);
    endproperty
    a_count_hold: assert property (p_count_hold) // RULE_01
        else $error("counter moved without a slow clock edge");

    property p_wake_from_halt;
        @(posedge clk_in) disable iff (rst_in)
        wake_out |-> (!halted_out && $past(halted_out));
    endproperty
    a_wake_from_halt: assert property (p_wake_from_halt) // RULE_16
        else $error("wake pulse without leaving halt");

    property p_service_wake;
        @(posedge clk_in) disable iff (rst_in)
        service_int_out |-> (wake_out && !core_reset_out);
    endproperty
    a_service_wake: assert property (p_service_wake) // RULE_19
        else $error("interrupt serviced without an interrupt wake");

    property p_core_reset_cause;
        @(posedge clk_in) disable iff (rst_in)
        core_reset_out |-> (wake_out && st_reg.timeout_flag && !full_reset_out);
    endproperty
    a_core_reset_cause: assert property (p_core_reset_cause) // RULE_11
        else $error("partial reset without an overflow wake");

    property p_full_reset_state;
        @(posedge clk_in) disable iff (rst_in)
        full_reset_out |-> (st_reg.ctrl == wdw_pkg::WDT_CTRL_RESET && st_reg.count == '0
            && !halted_out);
    endproperty
    a_full_reset_state: assert property (p_full_reset_state) // RULE_10
        else $error("full reset left control or counter dirty");

    property p_halt_mask;
        @(posedge clk_in) disable iff (rst_in)
        s_halt_taken |=> (!st_reg.timeout_flag
            && st_reg.int_pending_at_halt == $past(int_req_in));
    endproperty
    a_halt_mask: assert property (p_halt_mask) // RULE_20
        else $error("pending requests not captured at halt");

    property p_wake_keeps_pd;
        @(posedge clk_in) disable iff (rst_in)
        wake_out |-> st_reg.powerdown_flag;
    endproperty
    a_wake_keeps_pd: assert property (p_wake_keeps_pd) // RULE_15
        else $error("power-down flag lost on wake");

    property p_soft_flag_set;
        @(posedge clk_in) disable iff (rst_in)
        $rose(st_reg.soft_flag) |-> full_reset_out;
    endproperty
    a_soft_flag_set: assert property (p_soft_flag_set) // RULE_07
        else $error("soft reset flag set without a key reset");

    property p_timeout_set;
        @(posedge clk_in) disable iff (rst_in)
        $rose(st_reg.timeout_flag) |-> (full_reset_out || core_reset_out);
    endproperty
    a_timeout_set: assert property (p_timeout_set) // RULE_10 RULE_11
        else $error("timeout flag set without an overflow reset");
endmodule : wdw_watchdog
`default_nettype wire

// *** dv/wdw_watchdog_test.sv ***
// Purpose: Self-checking bench for the watchdog and wake-up block
// Assumes: Slow oscillator driven by the bench, four system clocks per slow period
// Notes:   Output pulses are counted by a monitor so scenarios compare counts
`default_nettype none
module wdw_watchdog_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       slow_osc_in = 1'b0;
    logic       reg_wr_in = 1'b0;
    logic       reg_rd_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] reg_rdata_out;
    logic       clear_watchdog_instr_in = 1'b0;
    logic       halt_in = 1'b0;
    logic [7:0] porta_in = 8'hff;
    logic [7:0] int_req_in = 8'h00;
    logic [7:0] int_en_in = 8'h00;
    logic       stack_full_in = 1'b0;
    logic       undervoltage_in = 1'b0;
    logic       halted_out;
    logic       wake_out;
    logic       service_int_out;
    logic       core_reset_out;
    logic       full_reset_out;
    int         n_errors = 0;
    int         comparisons = 0;
    int         n_full = 0;
    int         n_core = 0;
    int         n_wake = 0;
    int         n_serv = 0;
    int         f0;
    int         w0;
    int         s0;
    logic [7:0] d;

    wdw_watchdog i_wdw_watchdog (
        .clk_in(clk_in), .rst_in(rst_in), .slow_osc_in(slow_osc_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .clear_watchdog_instr_in(clear_watchdog_instr_in), .halt_in(halt_in), .porta_in(porta_in),
        .int_req_in(int_req_in), .int_en_in(int_en_in), .stack_full_in(stack_full_in),
        .undervoltage_in(undervoltage_in), .halted_out(halted_out), .wake_out(wake_out),
        .service_int_out(service_int_out), .core_reset_out(core_reset_out),
        .full_reset_out(full_reset_out)
    );

    always #5 clk_in = ~clk_in;

    // Pulses last one cycle, so counting at each edge sees every one
    always @(posedge clk_in) begin
        if (full_reset_out === 1'b1) n_full++;
        if (core_reset_out === 1'b1) n_core++;
        if (wake_out === 1'b1) n_wake++;
        if (service_int_out === 1'b1) n_serv++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_in);
        reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= v;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_in);
        reg_rd_in <= 1'b1; reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask : rd

    task automatic pulse(input int which);
        @(posedge clk_in);
        if (which == 0) clear_watchdog_instr_in <= 1'b1; else halt_in <= 1'b1;
        @(posedge clk_in);
        clear_watchdog_instr_in <= 1'b0; halt_in <= 1'b0;
    endtask : pulse

    // Slow clock only moves when asked, so counts are exact
    task automatic slow_edges(input int n);
        repeat (n) begin
            @(posedge clk_in) slow_osc_in <= 1'b1;
            repeat (2) @(posedge clk_in);
            slow_osc_in <= 1'b0;
            @(posedge clk_in);
        end
    endtask : slow_edges

    task automatic t_reset_values;
        rd(wdw_pkg::ADDR_WDT_CTRL, d);  check(d, 8'h53);
        rd(wdw_pkg::ADDR_RST_CAUSE, d); check(d, 8'h00);
        rd(wdw_pkg::ADDR_STATUS, d);    check(d, 8'h00);
        rd(wdw_pkg::ADDR_PA_WAKE, d);   check(d, 8'h00);
        rd(4'h9, d);                    check(d, 8'h00);
    endtask : t_reset_values

    task automatic t_keys;
        f0 = n_full;
        wr(wdw_pkg::ADDR_WDT_CTRL, 8'ha8);
        repeat (20) @(posedge clk_in);
        check(n_full, f0);
        rd(wdw_pkg::ADDR_WDT_CTRL, d); check(d, 8'ha8);
        wr(wdw_pkg::ADDR_WDT_CTRL, 8'h03);
        repeat (7) @(posedge clk_in);
        check(n_full, f0);
        repeat (8) @(posedge clk_in);
        check(n_full, f0 + 1);
        rd(wdw_pkg::ADDR_RST_CAUSE, d); check(d, 8'h01);
        rd(wdw_pkg::ADDR_WDT_CTRL, d);  check(d, 8'h53);
    endtask : t_keys

    task automatic t_run_overflow;
        for (int s = 0; s < 2; s++) begin
            wr(wdw_pkg::ADDR_WDT_CTRL, {wdw_pkg::KEY_A, 3'(s)});
            pulse(0);
            f0 = n_full;
            if (s == 0) begin
                slow_edges(200);
                pulse(0);
            end
            slow_edges((1 << (8 + 2 * s)) - 1);
            check(n_full, f0);
            slow_edges(1);
            repeat (3) @(posedge clk_in);
            check(n_full, f0 + 1);
            rd(wdw_pkg::ADDR_STATUS, d);    check(d, 8'h02);
            rd(wdw_pkg::ADDR_WDT_CTRL, d);  check(d, 8'h53);
        end
        rd(wdw_pkg::ADDR_RST_CAUSE, d); check(d, 8'h01);
        wr(wdw_pkg::ADDR_RST_CAUSE, 8'h00);
        rd(wdw_pkg::ADDR_RST_CAUSE, d); check(d, 8'h00);
    endtask : t_run_overflow

    task automatic t_halt_porta;
        wr(wdw_pkg::ADDR_PA_WAKE, 8'h01);
        pulse(1);
        @(posedge clk_in);
        check(halted_out, 1'b1);
        rd(wdw_pkg::ADDR_STATUS, d); check(d, 8'h01);
        w0 = n_wake;
        @(posedge clk_in) porta_in <= 8'hfd;
        repeat (5) @(posedge clk_in);
        check(n_wake, w0);
        porta_in <= 8'hff;
        @(posedge clk_in) porta_in <= 8'hfe;
        repeat (5) @(posedge clk_in);
        check(n_wake, w0 + 1);
        check(halted_out, 1'b0);
        porta_in <= 8'hff;
        pulse(0);
        rd(wdw_pkg::ADDR_STATUS, d); check(d, 8'h00);
    endtask : t_halt_porta

    task automatic t_halt_int;
        @(posedge clk_in);
        int_req_in <= 8'h01;
        int_en_in  <= 8'h02;
        pulse(1);
        w0 = n_wake; s0 = n_serv;
        repeat (6) @(posedge clk_in);
        check(n_wake, w0);
        int_req_in <= 8'h03;
        repeat (5) @(posedge clk_in);
        check(n_wake, w0 + 1);
        check(n_serv, s0 + 1);
        // Disabled request, then enabled request with no stack room
        for (int k = 0; k < 2; k++) begin
            int_req_in <= 8'h00;
            pulse(1);
            repeat (2) @(posedge clk_in);
            stack_full_in <= (k == 1);
            int_req_in <= (k == 0) ? 8'h04 : 8'h02;
            repeat (5) @(posedge clk_in);
            check(n_wake, w0 + 2 + k);
            check(n_serv, s0 + 1);
        end
        int_req_in <= 8'h00;
        stack_full_in <= 1'b0;
    endtask : t_halt_int

    task automatic t_halt_overflow;
        wr(wdw_pkg::ADDR_WDT_CTRL, {wdw_pkg::KEY_A, 3'h0});
        pulse(1);
        f0 = n_full; w0 = n_wake;
        slow_edges(255);
        check(n_wake, w0);
        slow_edges(1);
        repeat (3) @(posedge clk_in);
        check(n_wake, w0 + 1);
        check(n_core, 1);
        check(n_full, f0);
        rd(wdw_pkg::ADDR_STATUS, d);   check(d, 8'h03);
        rd(wdw_pkg::ADDR_WDT_CTRL, d); check(d, 8'h50);
    endtask : t_halt_overflow

    task automatic t_undervoltage;
        @(posedge clk_in) undervoltage_in <= 1'b1;
        @(posedge clk_in) undervoltage_in <= 1'b0;
        rd(wdw_pkg::ADDR_RST_CAUSE, d); check(d, 8'h04);
        wr(wdw_pkg::ADDR_RST_CAUSE, 8'h00);
        rd(wdw_pkg::ADDR_RST_CAUSE, d); check(d, 8'h00);
    endtask : t_undervoltage

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset_values();
        t_keys();
        t_run_overflow();
        t_halt_porta();
        t_halt_int();
        t_halt_overflow();
        t_undervoltage();
        end_of_test();
    end

    // About 7,000 cycles are expected; this allows several times that
    initial begin
        #500us;
        n_errors++;
        end_of_test();
    end
endmodule : wdw_watchdog_test
`default_nettype wire
